// ### shared/link_regs_consts.vh
// word indices (byte address is four times), fields, reset values for the link sync bank
`ifndef LINK_REGS_CONSTS_VH
`define LINK_REGS_CONSTS_VH
`define OFS_LINK_PAGE 12'h300
`define OFS_LANE_SYNC 12'h473
`define OFS_RESET_CTRL 12'h475
`define OFS_QUAL_CTRL 12'h476
`define OFS_IRQ_STATUS 12'h480
`define OFS_IRQ_MASK 12'h484
`define BIT_SOFT_RESET 3
`define BIT_FORCE_SYNC 2
`define BIT_FRAME_REPL 0
`define BIT_QUAL 4
`define RST_RESET_CTRL 8'h01
`define RST_QUAL_CTRL 8'h10
`define MASK_RESET_CTRL_WR 8'hFD
`define MASK_QUAL_CTRL_WR 8'h1E
`define NUM_LINKS 2
`define NUM_LANES 8
`endif

// ### logic/sync2.v
// two-flop synchroniser for a bus of levels
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter W = 8
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // data
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_reg <= {W{1'b0}};
      sync_reg <= {W{1'b0}};
    end
    else
    begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end
  assign q = sync_reg;
endmodule // sync2
`default_nettype wire

// ### logic/link_bank.v
// one link's copy of the control and status fields
`timescale 1ns/100ps
`default_nettype none
`include "link_regs_consts.vh"
module link_bank (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // register writes
  input wire wr_reset_ctrl,
  input wire wr_qual_ctrl,
  input wire [7:0] wdata,
  // lane status from the receiver core, already synchronised
  input wire [7:0] lane_sync_in,
  // raw lane error flags
  input wire [7:0] nit_err_in,
  input wire [7:0] rd_err_in,
  // register contents
  output reg [7:0] reset_ctrl_reg,
  output reg [7:0] qual_ctrl_reg,
  output reg [7:0] lane_sync_reg,
  output wire [7:0] rd_err_out
);
  wire soft_reset = reset_ctrl_reg[`BIT_SOFT_RESET];
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reset_ctrl_reg <= `RST_RESET_CTRL;
      qual_ctrl_reg <= `RST_QUAL_CTRL;
      lane_sync_reg <= 8'h00;
    end
    else
    begin
      if (wr_reset_ctrl)
        reset_ctrl_reg <= wdata & `MASK_RESET_CTRL_WR;
      if (wr_qual_ctrl)
        qual_ctrl_reg <= wdata & `MASK_QUAL_CTRL_WR;
      if (soft_reset)
        lane_sync_reg <= 8'h00;
      else
        lane_sync_reg <= lane_sync_in;
    end
  end
  // masking the rd error when nit coincides avoids double counting one bad symbol
  assign rd_err_out = qual_ctrl_reg[`BIT_QUAL] ? (rd_err_in & ~nit_err_in) : rd_err_in;
endmodule // link_bank
`default_nettype wire

// ### logic/serial_link_rx_sync_ctrl_regs.v
// ahb-lite register bank for the serial link receiver sync controls
`timescale 1ns/100ps
`default_nettype none
`include "link_regs_consts.vh"
// Overview of operation
// - eight read-only lane sync status bits, bit n for lane n, reset zero
// - lane sync, reset control and qualification fields banked per link, selected by the link page register; irq status and mask are shared
// - soft reset bit 3 holds that link's receiver in power-on state
// - force sync bit 2 asserts a sync request toward the transmitter
// - frame replacement bit 0 enables error frame replacement, resets to one
// - qualification bit 4 set masks rd errors concurrent with nit errors
// - qualification clear reports rd errors independently of nit errors
module serial_link_rx_sync_ctrl_regs #(
  parameter LINKS = `NUM_LINKS
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // lane status and errors from each link's receiver core
  input wire [LINKS*8-1:0] lane_sync_raw,
  input wire [LINKS*8-1:0] nit_err,
  input wire [LINKS*8-1:0] rd_err,
  // controls to each link's receiver core
  output wire [LINKS-1:0] link_soft_reset,
  output wire [LINKS-1:0] force_sync_request,
  output wire [LINKS-1:0] frame_replacement_enable,
  output wire [LINKS*8-1:0] rd_err_qualified,
  // interrupt
  output wire irq
);
  reg [7:0] page_reg;
  reg [7:0] irq_status_reg;
  reg [7:0] irq_mask_reg;
  reg [11:0] addr_reg;
  reg wr_pend_reg;
  // word index of the current address phase; byte address is four times the index
  wire [11:0] addr_idx;
  // lane status as software sees it, forced low while the paged link is in soft reset
  wire [7:0] lane_sync_rd;
  reg [7:0] prev_sync_reg;
  wire [LINKS*8-1:0] lane_sync_s;
  wire [LINKS*8-1:0] nit_s;
  wire [LINKS*8-1:0] rd_s;
  wire [LINKS*8-1:0] reset_ctrl_all;
  wire [LINKS*8-1:0] qual_ctrl_all;
  wire [LINKS*8-1:0] lane_sync_all;
  wire [LINKS*8-1:0] rd_q_all;
  wire [7:0] sel_page;
  wire [7:0] cur_reset_ctrl;
  wire [7:0] cur_qual_ctrl;
  wire [7:0] cur_lane_sync;
  wire [7:0] cur_rd_err;
  wire [7:0] sync_change;
  wire [7:0] irq_events;
  wire addr_phase;
  wire wr_reset_hit;
  wire wr_qual_hit;
  wire rd_status_hit;
  reg [31:0] rdata_next;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_phase = hsel & hready & htrans[1];
  assign addr_idx = haddr[13:2];

  // pin-level inputs from the link domain cross through two flops
  sync2 #(.W(LINKS*24)) in_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .d({lane_sync_raw, nit_err, rd_err}),
    .q({lane_sync_s, nit_s, rd_s})
  );

  // out-of-range pages fall back to link 0 rather than aliasing
  assign sel_page = (page_reg < LINKS) ? page_reg : 8'h00;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      addr_reg <= 12'h000;
      wr_pend_reg <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= addr_phase & hwrite;
      if (addr_phase)
        addr_reg <= addr_idx;
    end
  end

  assign wr_reset_hit = wr_pend_reg & (addr_reg == `OFS_RESET_CTRL);
  assign wr_qual_hit = wr_pend_reg & (addr_reg == `OFS_QUAL_CTRL);

  genvar g;
  generate
    for (g = 0; g < LINKS; g = g + 1)
    begin : gen_link
      link_bank bank (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_reset_ctrl(wr_reset_hit & (sel_page == g)),
        .wr_qual_ctrl(wr_qual_hit & (sel_page == g)),
        .wdata(hwdata[7:0]),
        .lane_sync_in(lane_sync_s[g*8 +: 8]),
        .nit_err_in(nit_s[g*8 +: 8]),
        .rd_err_in(rd_s[g*8 +: 8]),
        .reset_ctrl_reg(reset_ctrl_all[g*8 +: 8]),
        .qual_ctrl_reg(qual_ctrl_all[g*8 +: 8]),
        .lane_sync_reg(lane_sync_all[g*8 +: 8]),
        .rd_err_out(rd_q_all[g*8 +: 8])
      );
      assign link_soft_reset[g] = reset_ctrl_all[g*8 + `BIT_SOFT_RESET];
      assign force_sync_request[g] = reset_ctrl_all[g*8 + `BIT_FORCE_SYNC];
      assign frame_replacement_enable[g] = reset_ctrl_all[g*8 + `BIT_FRAME_REPL];
    end
  endgenerate

  assign rd_err_qualified = rd_q_all;
  assign cur_reset_ctrl = reset_ctrl_all[sel_page*8 +: 8];
  assign cur_qual_ctrl = qual_ctrl_all[sel_page*8 +: 8];
  assign cur_lane_sync = lane_sync_all[sel_page*8 +: 8];
  assign cur_rd_err = rd_q_all[sel_page*8 +: 8];

  // events: a lane of the paged link changes sync state, or a qualified rd error on the paged link
  assign sync_change = cur_lane_sync ^ prev_sync_reg;
  assign irq_events = sync_change | cur_rd_err;
  // the clear happens at the address edge, the same edge that captures the read data
  assign rd_status_hit = addr_phase & ~hwrite & (addr_idx == `OFS_IRQ_STATUS);
  // soft reset masks the status at once, before the bank's own copy clears
  assign lane_sync_rd = cur_reset_ctrl[`BIT_SOFT_RESET] ? 8'h00 : cur_lane_sync;

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      page_reg <= 8'h00;
      irq_status_reg <= 8'h00;
      irq_mask_reg <= 8'h00;
      prev_sync_reg <= 8'h00;
    end
    else
    begin
      prev_sync_reg <= cur_lane_sync;
      if (wr_pend_reg & (addr_reg == `OFS_LINK_PAGE))
        page_reg <= hwdata[7:0];
      if (wr_pend_reg & (addr_reg == `OFS_IRQ_MASK))
        irq_mask_reg <= hwdata[7:0];
      // a new event in the clearing read's cycle survives the clear
      if (rd_status_hit)
        irq_status_reg <= irq_events;
      else
        irq_status_reg <= irq_status_reg | irq_events;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // read data is chosen in the address phase; unmapped offsets read zero
  always @*
  begin
    rdata_next = 32'h00000000;
    case (addr_idx)
      `OFS_LINK_PAGE: rdata_next = {24'h000000, page_reg};
      `OFS_LANE_SYNC: rdata_next = {24'h000000, lane_sync_rd};
      `OFS_RESET_CTRL: rdata_next = {24'h000000, cur_reset_ctrl};
      `OFS_QUAL_CTRL: rdata_next = {24'h000000, cur_qual_ctrl};
      `OFS_IRQ_STATUS: rdata_next = {24'h000000, irq_status_reg};
      `OFS_IRQ_MASK: rdata_next = {24'h000000, irq_mask_reg};
      default: rdata_next = 32'h00000000;
    endcase
  end

  // registered read data stands for the data phase only; a write in the data phase
  // just before lands on the same edge, and zero wait states keep reads in order
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (addr_phase & ~hwrite)
      hrdata <= rdata_next;
    else
      hrdata <= 32'h00000000;
  end
endmodule // serial_link_rx_sync_ctrl_regs
`default_nettype wire

// ### test/regs_checker.sv
// concurrent checks on the link sync control register bank ports
`timescale 1ns/100ps
`default_nettype none
module regs_checker #(parameter LINKS = 2) (
  // bus
  input wire logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr, hwdata, hrdata,
  // receiver core side
  input wire logic [LINKS-1:0] link_soft_reset, force_sync_request, frame_replacement_enable,
  input wire logic [LINKS*8-1:0] nit_err, rd_err, rd_err_qualified
);
  logic r_q, w_q;
  logic [11:0] a_q;
  logic [7:0] pg;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // shadow of the address phase and of the link page selector
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      r_q <= 1'b0;
      w_q <= 1'b0;
      a_q <= 12'h000;
      pg <= 8'h00;
    end
    else if (hready)
    begin
      if (w_q && a_q == 12'h300)
        pg <= hwdata[7:0];
      r_q <= hsel && htrans[1] && !hwrite;
      w_q <= hsel && htrans[1] && hwrite;
      a_q <= haddr[13:2];
    end
  a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  a_reset_vals: assert property (!$past(hresetn) |-> frame_replacement_enable == {LINKS{1'b1}}
    && link_soft_reset == 0 && force_sync_request == 0) else $error("bad reset value");
  a_ctrl_cause: assert property ($changed({link_soft_reset, force_sync_request,
    frame_replacement_enable}) |-> $past(w_q) && $past(a_q) == 12'h475)
    else $error("control moved without a write");
  a_upper_zero: assert property (r_q |-> hrdata[31:8] == 24'h0) else $error("upper bits set");
  a_rsvd_ctrl: assert property (r_q && a_q == 12'h475 |-> !hrdata[1])
    else $error("reserved bit 1 set");
  a_rsvd_qual: assert property (r_q && a_q == 12'h476 |-> hrdata[7:5] == 3'h0)
    else $error("reserved bits 7:5 set");
  a_lane_hold: assert property (r_q && a_q == 12'h473 && link_soft_reset[(pg < LINKS) ? pg : 0]
    |-> hrdata == 32'h0) else $error("lane status during soft reset");
  a_rderr_pass: assert property (((rd_err_qualified ^ $past(rd_err, 2))
    & ~($past(rd_err, 2) & $past(nit_err, 2))) == 0) else $error("rd error misreported");
endmodule // regs_checker
bind serial_link_rx_sync_ctrl_regs regs_checker #(.LINKS(LINKS)) regs_checker_i (.*);
`default_nettype wire

// ### test/rx_core_model.sv
// behavioural receiver core: lane sync levels and lane error flags
`timescale 1ns/100ps
`default_nettype none
module rx_core_model #(parameter LINKS = 2) (
  // clock
  input wire logic hclk,
  // controls and stimulus
  input wire logic [LINKS-1:0] link_soft_reset, force_sync_request,
  input wire logic [LINKS*8-1:0] lanes_up, nit_set, rd_set,
  // status toward the bank
  output logic [LINKS*8-1:0] lane_sync_raw, nit_err, rd_err
);
  initial
  begin
    lane_sync_raw = '0;
    nit_err = '0;
    rd_err = '0;
  end
  // a link in reset or asked to resync reports no lane as synchronised
  always @(posedge hclk)
  begin
    for (int l = 0; l < LINKS; l++)
      lane_sync_raw[l*8 +: 8] <= (link_soft_reset[l] || force_sync_request[l]) ? 8'h00
        : lanes_up[l*8 +: 8];
    nit_err <= nit_set;
    rd_err <= rd_set;
  end
endmodule // rx_core_model
`default_nettype wire

// ### test/testbench.sv
// self-checking bench for the link sync control register bank
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp, irq;
  logic [1:0] htrans = 2'h0, srst, fsync, frepl;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] lanes_up = 16'h0, nit_set = 16'h0, rd_set = 16'h0, lsync, not_in_table_error, rde, rdq;
  int num_errors = 0, n_compared = 0, cyc = 0;
  serial_link_rx_sync_ctrl_regs #(.LINKS(2)) serial_link_rx_sync_ctrl_regs_i (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .lane_sync_raw(lsync), .nit_err(not_in_table_error), .rd_err(rde),
    .link_soft_reset(srst), .force_sync_request(fsync), .frame_replacement_enable(frepl),
    .rd_err_qualified(rdq), .irq(irq));
  rx_core_model #(.LINKS(2)) rx_core_model_i (.hclk(hclk), .link_soft_reset(srst),
    .force_sync_request(fsync), .lanes_up(lanes_up), .nit_set(nit_set), .rd_set(rd_set),
    .lane_sync_raw(lsync), .nit_err(not_in_table_error), .rd_err(rde));
  initial
    forever #12.5 hclk = ~hclk;
  task end_sim;
    $display("comparisons %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      end_sim;
    end
  end
  task chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    htrans <= 2'h2;
    haddr <= {18'h0, a, 2'b00};
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    q = hrdata;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rc(input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task t_defaults;
    rc(12'h473, 32'h0);
    rc(12'h475, 32'h1);
    rc(12'h476, 32'h10);
    rc(12'h7F0, 32'h0);
    chk(frepl, 32'h3);
  endtask
  task t_ctrl;
    wr(12'h475, 32'hFF);
    rc(12'h475, 32'hFD);
    chk(srst, 32'h1);
    chk(fsync, 32'h1);
    wr(12'h476, 32'hFF);
    rc(12'h476, 32'h1E);
    wr(12'h476, 32'h10);
    wr(12'h475, 32'h08);
    rc(12'h475, 32'h08);
    chk(frepl, 32'h2);
    wr(12'h475, 32'h09);
    wr(12'h475, 32'h01);
  endtask
  task t_page;
    wr(12'h300, 32'h1);
    wr(12'h475, 32'h4);
    rc(12'h475, 32'h4);
    chk(fsync, 32'h2);
    wr(12'h300, 32'h0);
    rc(12'h475, 32'h1);
    wr(12'h300, 32'h1);
    wr(12'h475, 32'h1);
    wr(12'h300, 32'h0);
  endtask
  task t_lanes;
    lanes_up <= 16'hA55A;
    repeat (6) @(posedge hclk);
    rc(12'h473, 32'h5A);
    wr(12'h300, 32'h1);
    rc(12'h473, 32'hA5);
    wr(12'h300, 32'h0);
    wr(12'h475, 32'h9);
    rc(12'h473, 32'h0);
    wr(12'h475, 32'h1);
    repeat (6) @(posedge hclk);
    rc(12'h473, 32'h5A);
  endtask
  task t_errors;
    xfer(1'b0, 12'h480, 32'h0);
    wr(12'h484, 32'hFF);
    nit_set <= 16'h1;
    rd_set <= 16'h1;
    repeat (4) @(posedge hclk);
    chk(rdq, 32'h0);
    chk(irq, 32'h0);
    rd_set <= 16'h2;
    repeat (6) @(posedge hclk);
    chk(rdq, 32'h2);
    chk(irq, 32'h1);
    rd_set <= 16'h0;
    nit_set <= 16'h0;
    repeat (4) @(posedge hclk);
    rc(12'h480, 32'h2);
    @(posedge hclk);
    chk(irq, 32'h0);
    wr(12'h484, 32'h0);
    rd_set <= 16'h2;
    repeat (6) @(posedge hclk);
    chk(irq, 32'h0);
    wr(12'h475, 32'h9);
    wr(12'h476, 32'h0);
    wr(12'h475, 32'h1);
    nit_set <= 16'h1;
    rd_set <= 16'h1;
    repeat (4) @(posedge hclk);
    chk(rdq, 32'h1);
  endtask
  initial
  begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_defaults;
    t_ctrl;
    t_page;
    t_lanes;
    t_errors;
    end_sim;
  end
endmodule // testbench
`default_nettype wire
